/* hdl/port_pkg.sv */
package port_pkg;

    // core clock and timing
    localparam int CLK_NS = 20;
    // strong pull-up lasts two oscillator periods; the oscillator is clk_sys
    localparam int STRONG_PU_PERIODS = 2;
    localparam logic [1:0] STRONG_PU_CYCLES = 2'(STRONG_PU_PERIODS);
    // glitches up to this width are rejected on the i2c serial inputs; the spi inputs are synchronised but not filtered
    localparam int GLITCH_NS = 50;
    localparam int GLITCH_CYCLES = GLITCH_NS / CLK_NS + 1;

    // latch reset values
    localparam logic [7:0] P1_RESET = 8'hff;
    localparam logic [7:0] P2_RESET = 8'hff;
    localparam logic [7:0] P3_RESET = 8'hff;

    // port 1 field positions
    localparam int P1_STRONG_LO = 0;
    localparam int P1_ANALOG_LO = 2;
    localparam int P1_ANALOG_W = 6;

    // port 3 alternate function positions
    localparam int P3_RXD = 0;
    localparam int P3_TXD = 1;
    localparam int P3_EXT_INTERRUPT_ZERO = 2;
    localparam int P3_EXT_INTERRUPT_ONE = 3;
    localparam int P3_T0 = 4;
    localparam int P3_T1 = 5;
    localparam int P3_WRS = 6;
    localparam int P3_RDS = 7;

    // latch selected by the cpu
    typedef enum logic [1:0] {
        PORT_NONE = 2'b00,
        PORT_1    = 2'b01,
        PORT_2    = 2'b10,
        PORT_3    = 2'b11
    } port_sel_e;

    // single-bit write operations
    typedef enum logic [1:0] {
        BIT_NONE = 2'b00,
        BIT_CLR  = 2'b01,
        BIT_SET  = 2'b10,
        BIT_MOVC = 2'b11
    } bit_op_e;

    // port 2 address emission phase
    typedef enum logic [1:0] {
        EXT_IDLE      = 2'b00,
        EXT_FETCH     = 2'b01,
        EXT_DATA_MID  = 2'b10,
        EXT_DATA_HIGH = 2'b11
    } ext_phase_e;

endpackage

/* hdl/pin_conditioner.sv */
`timescale 1ns/10ps
`default_nettype none

// two-flop synchroniser with an optional stability filter
module pin_conditioner #(
    parameter int WIDTH = 1,
    parameter int FILTER_CYCLES = 0
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             srst,
    // raw and conditioned levels
    input  wire logic [WIDTH-1:0] pin_raw,
    output logic      [WIDTH-1:0] pin_clean
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // synchroniser; meta_reg feeds sync_reg only
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            meta_reg <= '1;
            sync_reg <= '1;
        end
        else
        begin
            meta_reg <= pin_raw;
            sync_reg <= meta_reg;
        end
    end

    genvar g;
    generate
        if (FILTER_CYCLES == 0)
        begin : g_plain
            assign pin_clean = sync_reg;
        end
        else
        begin : g_filt
            for (g = 0; g < WIDTH; g++)
            begin : g_bit
                logic [3:0] stable_reg;
                logic       level_reg;
                // accept a new level only after it stays put long enough
                always_ff @(posedge clk_sys)
                begin
                    if (srst)
                    begin
                        stable_reg <= 4'h0;
                        level_reg <= 1'b1;
                    end
                    else if (sync_reg[g] == level_reg)
                        stable_reg <= 4'h0;
                    else if (stable_reg == 4'(FILTER_CYCLES - 1))
                    begin
                        level_reg <= sync_reg[g];
                        stable_reg <= 4'h0;
                    end
                    else
                        stable_reg <= stable_reg + 4'h1;
                end
                assign pin_clean[g] = level_reg;
            end
        end
    endgenerate

endmodule

`default_nettype wire

/* hdl/port_pins.sv */
`timescale 1ns/10ps
`default_nettype none

module port_pins (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       srst,
    // cpu latch access
    input  wire logic [1:0] port_sel,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    input  wire logic [1:0] bit_op,
    input  wire logic [2:0] bit_idx,
    input  wire logic       carry_in,
    input  wire logic       rd_en,
    input  wire logic       rd_rmw,
    output logic      [7:0] rd_data,
    output logic            rd_valid,
    // latch views
    output logic      [7:0] port1_latch_register,
    output logic      [7:0] port2_latch_register,
    output logic      [7:0] port3_latch_register,
    // port 1 strong pins
    input  wire logic [1:0] strong_pin_in,
    output logic      [1:0] strong_pin_out,
    output logic      [1:0] strong_pin_oe,
    input  wire logic [1:0] pwm_route,
    input  wire logic       pwm_channel_zero_out,
    input  wire logic       pwm_channel_one_out,
    output logic            timer2_count_input,
    output logic            timer2_capture_trigger,
    // port 1 analog-capable pins
    input  wire logic [5:0] analog_capable_inputs,
    output logic      [5:0] analog_select,
    // port 2 pins and external memory
    input  wire logic [7:0] p2_in,
    output logic      [7:0] p2_out,
    output logic      [7:0] p2_oe,
    input  wire logic [1:0] ext_phase,
    input  wire logic [23:0] ext_addr,
    // port 3 pins and alternate functions
    input  wire logic [7:0] p3_in,
    output logic      [7:0] p3_out,
    output logic      [7:0] p3_oe,
    input  wire logic       uart_txd,
    input  wire logic       uart_rxd_out,
    input  wire logic       ext_write_strobe_n,
    input  wire logic       ext_read_strobe_n,
    output logic            uart_rxd_in,
    output logic            ext_interrupt_zero,
    output logic            ext_interrupt_one,
    output logic            timer0_count_input,
    output logic            timer1_count_input,
    // dedicated serial pins
    input  wire logic       serial_mode_select,
    input  wire logic       serial_clock_pin_in,
    output logic            serial_clock_pin_out,
    output logic            serial_clock_pin_oe,
    input  wire logic       serial_data_pin_in,
    output logic            serial_data_pin_out,
    output logic            serial_data_pin_oe,
    output logic      [1:0] serial_strong_pullup,
    input  wire logic       spi_sclk_out,
    input  wire logic       spi_mosi_out,
    input  wire logic       i2c_scl_low,
    input  wire logic       i2c_sda_low,
    input  wire logic       i2c_sw_enable,
    input  wire logic       i2c_sw_scl,
    input  wire logic       i2c_sw_sda,
    output logic            i2c_scl_in,
    output logic            i2c_sda_in,
    output logic            spi_sclk_in,
    output logic            spi_data_in
);

    logic [7:0]  p1_reg;
    logic [7:0]  p2_reg;
    logic [7:0]  p3_reg;
    logic [7:0]  cur_latch;
    logic [7:0]  bit_next;
    logic [1:0]  strong_sync;
    logic [5:0]  analog_sync;
    logic [7:0]  p2_sync;
    logic [7:0]  p3_sync;
    logic [1:0]  serial_sync;
    logic [1:0]  serial_filt;
    logic [17:0] quasi_val;
    logic [17:0] quasi_prev_reg;
    logic [1:0]  pu_cnt_reg [18];
    logic [17:0] pu_on;
    logic [7:0]  p3_alt_out;
    logic [7:0]  p2_addr;
    logic        p2_ctrl;
    logic [1:0]  pwm_val;
    logic [7:0]  pin_view;

    // pin synchronisers
    // two-flop sync
    pin_conditioner #(.WIDTH(26), .FILTER_CYCLES(0)) u_sync (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .pin_raw   ({strong_pin_in, analog_capable_inputs, p2_in, p3_in, serial_clock_pin_in,
                     serial_data_pin_in}),
        .pin_clean ({strong_sync, analog_sync, p2_sync, p3_sync, serial_sync})
    );

    pin_conditioner #(.WIDTH(2), .FILTER_CYCLES(port_pkg::GLITCH_CYCLES)) u_filt (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .pin_raw   ({serial_clock_pin_in, serial_data_pin_in}),
        .pin_clean (serial_filt)
    );

    // latch currently addressed
    always_comb
    begin
        unique case (port_pkg::port_sel_e'(port_sel))
            port_pkg::PORT_1: cur_latch = p1_reg;
            port_pkg::PORT_2: cur_latch = p2_reg;
            port_pkg::PORT_3: cur_latch = p3_reg;
            port_pkg::PORT_NONE: cur_latch = 8'h00;
        endcase
    end

    always_comb
    begin
        bit_next = cur_latch;
        unique case (port_pkg::bit_op_e'(bit_op))
            port_pkg::BIT_CLR: bit_next[bit_idx] = 1'b0;
            port_pkg::BIT_SET: bit_next[bit_idx] = 1'b1;
            port_pkg::BIT_MOVC: bit_next[bit_idx] = carry_in;
            port_pkg::BIT_NONE: bit_next = cur_latch;
        endcase
    end

    // port latches; byte write wins over a bit op
    // reset to all ones; port 1 pins 7:2 come up analog
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            p1_reg <= port_pkg::P1_RESET;
            p2_reg <= port_pkg::P2_RESET;
            p3_reg <= port_pkg::P3_RESET;
        end
        else if (wr_en || bit_op != 2'b00)
        begin
            unique case (port_pkg::port_sel_e'(port_sel))
                port_pkg::PORT_1: p1_reg <= wr_en ? wr_data : bit_next;
                port_pkg::PORT_2: p2_reg <= wr_en ? wr_data : bit_next;
                port_pkg::PORT_3: p3_reg <= wr_en ? wr_data : bit_next;
                port_pkg::PORT_NONE: p1_reg <= p1_reg;
            endcase
        end
    end

    assign port1_latch_register = p1_reg;
    assign port2_latch_register = p2_reg;
    assign port3_latch_register = p3_reg;

    // synchronised pin view of the addressed port
    always_comb
    begin
        unique case (port_pkg::port_sel_e'(port_sel))
            port_pkg::PORT_1: pin_view = {analog_sync & ~p1_reg[7:2], strong_sync};
            port_pkg::PORT_2: pin_view = p2_sync;
            port_pkg::PORT_3: pin_view = p3_sync;
            port_pkg::PORT_NONE: pin_view = 8'h00;
        endcase
    end

    // read port
    // latch on rmw
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
        end
        else
        begin
            rd_valid <= rd_en;
            if (rd_en)
                rd_data <= rd_rmw ? cur_latch : pin_view;
        end
    end

    assign pwm_val = {pwm_channel_one_out, pwm_channel_zero_out};
    assign timer2_count_input = strong_sync[0] & p1_reg[0];
    assign timer2_capture_trigger = strong_sync[1] & p1_reg[1];

    assign analog_select = p1_reg[7:2];

    always_comb
    begin
        unique case (port_pkg::ext_phase_e'(ext_phase))
            port_pkg::EXT_FETCH: p2_addr = ext_addr[15:8];
            port_pkg::EXT_DATA_MID: p2_addr = ext_addr[15:8];
            port_pkg::EXT_DATA_HIGH: p2_addr = ext_addr[23:16];
            port_pkg::EXT_IDLE: p2_addr = 8'h00;
        endcase
    end
    assign p2_ctrl = (ext_phase != 2'b00);

    always_comb
    begin
        p3_alt_out = 8'hff;
        p3_alt_out[port_pkg::P3_RXD] = uart_rxd_out;
        p3_alt_out[port_pkg::P3_TXD] = uart_txd;
        p3_alt_out[port_pkg::P3_WRS] = ext_write_strobe_n;
        p3_alt_out[port_pkg::P3_RDS] = ext_read_strobe_n;
    end

    assign uart_rxd_in = p3_sync[port_pkg::P3_RXD] & p3_reg[port_pkg::P3_RXD];
    assign ext_interrupt_zero = p3_sync[port_pkg::P3_EXT_INTERRUPT_ZERO] & p3_reg[port_pkg::P3_EXT_INTERRUPT_ZERO];
    assign ext_interrupt_one = p3_sync[port_pkg::P3_EXT_INTERRUPT_ONE] & p3_reg[port_pkg::P3_EXT_INTERRUPT_ONE];
    assign timer0_count_input = p3_sync[port_pkg::P3_T0] & p3_reg[port_pkg::P3_T0];
    assign timer1_count_input = p3_sync[port_pkg::P3_T1] & p3_reg[port_pkg::P3_T1];

    // levels asked of quasi-bidirectional pins: port 3, port 2, strong pins
    assign quasi_val = {p3_reg & p3_alt_out, p2_reg, p1_reg[1:0]};

    genvar g;
    generate
        for (g = 0; g < 18; g++)
        begin : g_pu
            always_ff @(posedge clk_sys)
            begin
                if (srst)
                    pu_cnt_reg[g] <= 2'h0;
                else if (quasi_val[g] && !quasi_prev_reg[g])
                    pu_cnt_reg[g] <= port_pkg::STRONG_PU_CYCLES - 2'h1;
                else if (pu_cnt_reg[g] != 2'h0)
                    pu_cnt_reg[g] <= pu_cnt_reg[g] - 2'h1;
            end
            // rise cycle itself counts as the first strong cycle
            assign pu_on[g] = (pu_cnt_reg[g] != 2'h0) || (quasi_val[g] && !quasi_prev_reg[g]);
        end
    endgenerate

    // previous requested levels for edge detection
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            quasi_prev_reg <= 18'h3ffff;
        else
            quasi_prev_reg <= quasi_val;
    end

    // strong pin drivers
    // quasi drive
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            if (pwm_route[i])
            begin
                strong_pin_out[i] = pwm_val[i];
                strong_pin_oe[i] = 1'b1;
            end
            else
            begin
                strong_pin_out[i] = quasi_val[i];
                strong_pin_oe[i] = ~quasi_val[i] | pu_on[i];
            end
        end
    end

    // port 2 drivers
    // push-pull address
    assign p2_out = p2_ctrl ? p2_addr : p2_reg;
    assign p2_oe = p2_ctrl ? 8'hff : (~p2_reg | pu_on[9:2]);

    assign p3_out = quasi_val[17:10];
    assign p3_oe = ~quasi_val[17:10] | pu_on[17:10];

    // serial pins
    // mode drive
    always_comb
    begin
        if (serial_mode_select)
        begin
            serial_clock_pin_out = spi_sclk_out;
            serial_clock_pin_oe = 1'b1;
            serial_data_pin_out = spi_mosi_out;
            serial_data_pin_oe = 1'b1;
        end
        else
        begin
            serial_clock_pin_out = 1'b0;
            serial_clock_pin_oe = i2c_scl_low | (i2c_sw_enable & ~i2c_sw_scl);
            serial_data_pin_out = 1'b0;
            serial_data_pin_oe = i2c_sda_low | (i2c_sw_enable & ~i2c_sw_sda);
        end
    end
    assign serial_strong_pullup = {2{serial_mode_select}};
    assign i2c_scl_in = serial_filt[1];
    assign i2c_sda_in = serial_filt[0];
    assign spi_sclk_in = serial_sync[1];
    assign spi_data_in = serial_sync[0];

    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    sequence s_rise(int i);
        !quasi_val[i] ##1 quasi_val[i];
    endsequence

    chk_strong_pulse: assert property (
        s_rise(2) |-> p2_oe[0] ##1 p2_oe[0] ##1 (!p2_oe[0] || !p2_reg[0] || p2_ctrl))
        else $error("strong pull-up width wrong");
    chk_p1_low_drive: assert property (
        (!p1_reg[0] && !pwm_route[0]) |-> (strong_pin_oe[0] && !strong_pin_out[0]))
        else $error("strong pin not driven low");
    chk_pwm_over: assert property (
        pwm_route[1] |-> (strong_pin_oe[1] && strong_pin_out[1] == pwm_channel_one_out))
        else $error("pwm does not own pin");
    chk_t2_gate: assert property (
        !p1_reg[0] |-> !timer2_count_input)
        else $error("timer 2 input not gated");
    chk_p2_addr: assert property (
        (ext_phase == 2'b11) |-> (p2_oe == 8'hff && p2_out == ext_addr[23:16]))
        else $error("port 2 address drive wrong");
    chk_p2_latch_kept: assert property (
        (p2_ctrl && !wr_en && bit_op == 2'b00) |=> $stable(p2_reg))
        else $error("port 2 latch changed");
    chk_p3_gate: assert property (
        !p3_reg[port_pkg::P3_TXD] |-> (p3_oe[1] && !p3_out[1]))
        else $error("port 3 alternate not gated");
    chk_i2c_weak: assert property (
        !serial_mode_select |-> (!serial_clock_pin_out && !serial_data_pin_out))
        else $error("i2c pins driven high");
    chk_rmw_read: assert property (
        (rd_en && rd_rmw && port_sel == 2'b11) |=> (rd_valid && rd_data == $past(p3_reg)))
        else $error("rmw read did not return latch");
    chk_bit_op: assert property (
        (!wr_en && bit_op == 2'b10 && port_sel == 2'b11)
            |=> (p3_reg == ($past(p3_reg) | (8'h01 << $past(bit_idx)))))
        else $error("bit set changed wrong bits");

endmodule

`default_nettype wire

/* sim/pin_world.sv */
`timescale 1ns/10ps
`default_nettype none

// external circuits hanging on the port and serial wires
module pin_world (
    // device drivers, one bit a wire
    input  wire logic [19:0] drv_out,
    input  wire logic [19:0] drv_oe,
    // external drivers, one bit a wire
    input  wire logic [19:0] ext_en,
    input  wire logic [19:0] ext_val,
    // resolved wire levels
    output logic      [19:0] pin_lvl
);

    // weak pull-ups
    // device first, then outside driver, else pulled high; a fight is unknown
    always_comb
    begin
        for (int i = 0; i < 20; i++)
        begin
            if (drv_oe[i] && ext_en[i] && (drv_out[i] != ext_val[i]))
                pin_lvl[i] = 1'bx;
            else if (drv_oe[i])
                pin_lvl[i] = drv_out[i];
            else if (ext_en[i])
                pin_lvl[i] = ext_val[i];
            else
                pin_lvl[i] = 1'b1;
        end
    end

endmodule
`default_nettype wire

/* sim/port_pins_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

module port_pins_tb_top;

    // design connections
    logic        clk_sys, srst, wr_en, rd_en, rd_rmw, carry_in, rd_valid;
    logic        pwm_channel_zero_out, pwm_channel_one_out, timer2_count_input;
    logic        timer2_capture_trigger, uart_txd, uart_rxd_out, uart_rxd_in;
    logic        ext_write_strobe_n, ext_read_strobe_n, ext_interrupt_zero, ext_interrupt_one;
    logic        timer0_count_input, timer1_count_input, serial_mode_select;
    logic        serial_clock_pin_in, serial_clock_pin_out, serial_clock_pin_oe;
    logic        serial_data_pin_in, serial_data_pin_out, serial_data_pin_oe;
    logic        spi_sclk_out, spi_mosi_out, i2c_scl_low, i2c_sda_low, i2c_sw_enable;
    logic        i2c_sw_scl, i2c_sw_sda, i2c_scl_in, i2c_sda_in, spi_sclk_in, spi_data_in;
    logic [1:0]  port_sel, bit_op, pwm_route, ext_phase, serial_strong_pullup;
    logic [1:0]  strong_pin_in, strong_pin_out, strong_pin_oe;
    logic [2:0]  bit_idx, bi;
    logic [5:0]  analog_capable_inputs, analog_select;
    logic [7:0]  wr_data, rd_data, p2_in, p2_out, p2_oe, p3_in, p3_out, p3_oe, v;
    logic [7:0]  port1_latch_register, port2_latch_register, port3_latch_register;
    logic [23:0] ext_addr;
    logic [19:0] pin_lvl, ext_en, ext_val;
    logic        bc;
    logic [7:0]  exp_q[$];
    int          n_fail, samples_checked, k;

    // wires: strong 1:0, port 2 9:2, port 3 17:10, serial clock 18, data 19
    assign {serial_data_pin_in, serial_clock_pin_in, p3_in, p2_in, strong_pin_in} = pin_lvl;

    // device under test
    port_pins u_port_pins (
        .clk_sys, .srst, .port_sel, .wr_en, .wr_data, .bit_op, .bit_idx, .carry_in,
        .rd_en, .rd_rmw, .rd_data, .rd_valid, .port1_latch_register,
        .port2_latch_register, .port3_latch_register, .strong_pin_in, .strong_pin_out,
        .strong_pin_oe, .pwm_route, .pwm_channel_zero_out, .pwm_channel_one_out,
        .timer2_count_input, .timer2_capture_trigger, .analog_capable_inputs,
        .analog_select, .p2_in, .p2_out, .p2_oe, .ext_phase, .ext_addr, .p3_in, .p3_out,
        .p3_oe, .uart_txd, .uart_rxd_out, .ext_write_strobe_n, .ext_read_strobe_n,
        .uart_rxd_in, .ext_interrupt_zero, .ext_interrupt_one, .timer0_count_input,
        .timer1_count_input, .serial_mode_select, .serial_clock_pin_in,
        .serial_clock_pin_out, .serial_clock_pin_oe, .serial_data_pin_in,
        .serial_data_pin_out, .serial_data_pin_oe, .serial_strong_pullup, .spi_sclk_out,
        .spi_mosi_out, .i2c_scl_low, .i2c_sda_low, .i2c_sw_enable, .i2c_sw_scl,
        .i2c_sw_sda, .i2c_scl_in, .i2c_sda_in, .spi_sclk_in, .spi_data_in
    );

    // outside world on the pins
    pin_world u_pin_world (
        .drv_out ({serial_data_pin_out, serial_clock_pin_out, p3_out, p2_out, strong_pin_out}),
        .drv_oe  ({serial_data_pin_oe, serial_clock_pin_oe, p3_oe, p2_oe, strong_pin_oe}),
        .ext_en  (ext_en),
        .ext_val (ext_val),
        .pin_lvl (pin_lvl)
    );

    // 50 MHz core clock
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // compare one value
    task automatic chk(input logic [7:0] seen, input logic [7:0] expv);
        samples_checked++;
        if (seen !== expv)
        begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // one latch access: byte write or bit operation
    task automatic acc(input logic [1:0] p, input logic we, input logic [7:0] d,
                       input logic [1:0] op, input logic [2:0] i, input logic c);
        @(negedge clk_sys);
        {port_sel, wr_en, wr_data, bit_op, bit_idx, carry_in} = {p, we, d, op, i, c};
        @(negedge clk_sys);
        {wr_en, bit_op} = 3'h0;
    endtask

    // read request, expected answer noted first
    task automatic rd(input logic [1:0] p, input logic rmw, input logic [7:0] e);
        exp_q.push_back(e);
        @(negedge clk_sys);
        {port_sel, rd_rmw, rd_en} = {p, rmw, 1'b1};
        @(negedge clk_sys);
        rd_en = 1'b0;
    endtask

    task automatic end_of_test;
        if (n_fail == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // read answers against the oldest note
    always @(negedge clk_sys)
    begin
        if (rd_valid === 1'b1)
            chk(rd_data, (exp_q.size() > 0) ? exp_q.pop_front() : ~rd_data);
    end

    initial
    begin
        {n_fail, samples_checked} = '0;
        {srst, port_sel, wr_en, wr_data, bit_op, bit_idx, carry_in, rd_en, rd_rmw} = 20'h80000;
        {pwm_route, pwm_channel_zero_out, pwm_channel_one_out, ext_phase, ext_addr} = '0;
        {uart_txd, uart_rxd_out, ext_write_strobe_n, ext_read_strobe_n} = 4'hf;
        {serial_mode_select, spi_sclk_out, spi_mosi_out, i2c_scl_low, i2c_sda_low} = '0;
        {i2c_sw_enable, i2c_sw_scl, i2c_sw_sda, ext_en, ext_val} = 43'h3_0000000000;
        analog_capable_inputs = 6'h00;
        void'($urandom(26));
        cyc(10);
        srst = 1'b0;
        cyc(2);
        chk(port1_latch_register, port_pkg::P1_RESET);
        chk(port2_latch_register, port_pkg::P2_RESET);
        chk(port3_latch_register, port_pkg::P3_RESET);
        chk({2'h0, analog_select}, 8'h3f);
        chk(p2_oe | p3_oe, 8'h00);
        // port 2 latch and pin reads
        repeat (4)
        begin
            v = 8'($urandom);
            acc(2'h2, 1'b1, v, 2'h0, 3'h0, 1'b0);
            ext_en[9:2] = 8'($urandom);
            cyc(4);
            chk(p2_oe, ~v);
            rd(2'h2, 1'b1, v);
            rd(2'h2, 1'b0, v & ~ext_en[9:2]);
            ext_en = '0;
        end
        for (int op = 1; op < 4; op++)
        begin
            v = 8'($urandom);
            bi = 3'($urandom);
            bc = 1'($urandom);
            acc(2'h3, 1'b1, v, 2'h0, 3'h0, 1'b0);
            acc(2'h3, 1'b0, 8'h00, 2'(op), bi, bc);
            v[bi] = (op == 1) ? 1'b0 : ((op == 2) ? 1'b1 : bc);
            rd(2'h3, 1'b1, v);
        end
        // low drive, then two-cycle strong pull-up
        acc(2'h1, 1'b1, 8'hfe, 2'h0, 3'h0, 1'b0);
        chk({6'h0, strong_pin_oe[0], strong_pin_out[0]}, 8'h02);
        acc(2'h1, 1'b1, 8'hff, 2'h0, 3'h0, 1'b0);
        for (k = 0; k < 3; k++)
        begin
            chk({7'h0, strong_pin_oe[0]}, {7'h0, k < 2});
            cyc(1);
        end
        // pwm override and timer 2 inputs following the pins
        pwm_route = 2'b11;
        acc(2'h1, 1'b1, 8'hfc, 2'h0, 3'h0, 1'b0);
        repeat (4)
        begin
            {pwm_channel_one_out, pwm_channel_zero_out} = 2'($urandom);
            cyc(1);
            chk({4'h0, strong_pin_oe, strong_pin_out},
                {6'h3, pwm_channel_one_out, pwm_channel_zero_out});
        end
        pwm_route = 2'b00;
        cyc(1);
        chk({6'h0, strong_pin_out}, 8'h00);
        acc(2'h1, 1'b1, 8'hff, 2'h0, 3'h0, 1'b0);
        cyc(3);
        ext_en[1:0] = 2'b11;
        ext_val[1:0] = 2'b01;
        cyc(3);
        chk({6'h0, timer2_capture_trigger, timer2_count_input}, 8'h01);
        ext_en = '0;
        v = {6'($urandom), 2'b11};
        acc(2'h1, 1'b1, v, 2'h0, 3'h0, 1'b0);
        analog_capable_inputs = 6'($urandom);
        cyc(4);
        chk({2'h0, analog_select}, {2'h0, v[7:2]});
        rd(2'h1, 1'b0, {~v[7:2] & analog_capable_inputs, 2'b11});
        v = 8'($urandom);
        acc(2'h2, 1'b1, v, 2'h0, 3'h0, 1'b0);
        ext_addr = 24'($urandom);
        for (int ph = 1; ph < 4; ph++)
        begin
            ext_phase = 2'(ph);
            cyc(1);
            chk(p2_oe, 8'hff);
            chk(p2_out, (ph == 3) ? ext_addr[23:16] : ext_addr[15:8]);
        end
        ext_phase = 2'h0;
        cyc(3);
        chk(port2_latch_register, v);
        chk(p2_oe, ~v);
        acc(2'h3, 1'b1, 8'hff, 2'h0, 3'h0, 1'b0);
        {ext_read_strobe_n, ext_write_strobe_n, uart_txd, uart_rxd_out} = 4'($urandom);
        cyc(3);
        v = pin_lvl[17:10];
        chk({4'h0, v[7:6], v[1:0]}, {4'h0, ext_read_strobe_n, ext_write_strobe_n,
            uart_txd, uart_rxd_out});
        {ext_read_strobe_n, ext_write_strobe_n, uart_txd, uart_rxd_out} = 4'hf;
        acc(2'h3, 1'b1, 8'hfb, 2'h0, 3'h0, 1'b0);
        cyc(2);
        ext_en[17:10] = 8'h39;
        ext_val[17:10] = 8'($urandom);
        cyc(4);
        chk({3'h0, timer1_count_input, timer0_count_input, ext_interrupt_one,
            ext_interrupt_zero, uart_rxd_in}, {3'h0, ext_val[15:13], 1'b0,
            ext_val[10]});
        ext_en = '0;
        acc(2'h3, 1'b1, 8'h00, 2'h0, 3'h0, 1'b0);
        chk(pin_lvl[17:10], 8'h00);
        serial_mode_select = 1'b1;
        {spi_sclk_out, spi_mosi_out} = 2'($urandom);
        cyc(1);
        chk({2'h0, serial_strong_pullup, serial_clock_pin_oe, serial_clock_pin_out,
            serial_data_pin_oe, serial_data_pin_out}, {5'h07, spi_sclk_out, 1'b1,
            spi_mosi_out});
        serial_mode_select = 1'b0;
        i2c_scl_low = 1'b1;
        cyc(1);
        chk({4'h0, serial_strong_pullup, pin_lvl[19:18]}, 8'h02);
        i2c_scl_low = 1'b0;
        i2c_sw_enable = 1'b1;
        {i2c_sw_sda, i2c_sw_scl} = 2'($urandom);
        cyc(8);
        chk({4'h0, pin_lvl[19:18], i2c_sda_in, i2c_scl_in},
            {4'h0, {2{i2c_sw_sda, i2c_sw_scl}}});
        // short pulses ignored, long ones pass
        {i2c_sw_enable, i2c_sw_sda, i2c_sw_scl} = 3'h3;
        cyc(8);
        ext_en[19] = 1'b1;
        cyc(2);
        ext_en[19] = 1'b0;
        bc = 1'b0;
        repeat (10)
        begin
            cyc(1);
            bc = bc | (i2c_sda_in !== 1'b1);
        end
        chk({7'h0, bc}, 8'h00);
        ext_en[19] = 1'b1;
        for (k = 0; k < 20 && i2c_sda_in !== 1'b0; k++)
            cyc(1);
        chk({7'h0, i2c_sda_in}, 8'h00);
        ext_en = '0;
        for (k = 0; k < 10 && exp_q.size() > 0; k++)
            cyc(1);
        if (exp_q.size() > 0)
            n_fail++;
        end_of_test();
    end

endmodule
`default_nettype wire
